// ### rtl/wdt_regs.vh
/*
 * Register map, field positions, reset values, keys and timing counts
 * of the watchdog and interval timer.
 * Assumes inclusion by the timer module only; definitions only.
 */
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// ****************************************
// addresses
// ****************************************
`define WDT_ADDR_CTRL 16'hff74
`define WDT_ADDR_CNT 16'hff75
`define WDT_ADDR_RSTW 16'hff76
`define WDT_ADDR_RSTR 16'hff77

// ****************************************
// upper-byte keys of protected word writes
// ****************************************
`define WDT_KEY_CTRL 8'ha5
`define WDT_KEY_CNT 8'h5a
`define WDT_KEY_WCLR 8'ha5
`define WDT_KEY_RCFG 8'h5a

// ****************************************
// reset values
// ****************************************
`define WDT_CTRL_RESET 8'h00
`define WDT_CNT_RESET 8'h00
`define WDT_RESET_CONTROL_STATUS_RESET 8'h1f
`define WDT_RSV_ONES 5'h1f

// ****************************************
// timer_control fields
// ****************************************
`define WDT_CTRL_OVF 7
`define WDT_CTRL_MODE 6
`define WDT_CTRL_TME 5
`define WDT_CTRL_PSS 4
`define WDT_CTRL_ACT 3
`define WDT_CTRL_CKS_HI 2
`define WDT_CTRL_CKS_LO 0

// ****************************************
// reset_control_status fields
// ****************************************
`define WDT_RST_WATCHDOG_OVERFLOW_FLAG 7
`define WDT_RST_RESET_ENABLE_BIT 6
`define WDT_RST_RESET_TYPE_BIT 5

// ****************************************
// timing
// ****************************************
`define WDT_CLK_PS 4000
`define WDT_STATE_PS 4000
`define WDT_HOLD_RESET_ENABLE_BIT_STATES 132
`define WDT_HOLD_NORST_STATES 130
`define WDT_HOLD_RESET_ENABLE_BIT_CYC ((`WDT_HOLD_RESET_ENABLE_BIT_STATES * `WDT_STATE_PS) / `WDT_CLK_PS)
`define WDT_HOLD_NORST_CYC ((`WDT_HOLD_NORST_STATES * `WDT_STATE_PS) / `WDT_CLK_PS)

`endif

// ### rtl/wdt_timer.v
/*
 * Watchdog and interval timer: prescaler, 8-bit counter, timer_control,
 * reset_control_status, keyed word writes and byte reads.
 * Assumes all inputs synchronous to core_clk; rst_n is the external reset pin.
 */
// Functional notes
// - reset_control_status loads 1F only from external reset, not own overflow reset.
// - watchdog overflow flag sets on FF to 00 rollover in watchdog mode only.
// - watchdog flag clears only by read-with-1 then writing 0; writing 1 ignored.
// - reset-enable 0: no chip reset, but counter and timer_control are reset.
// - reset-type 0 selects power-on reset; software keeps it 0.
// - low five bits of reset_control_status read 1, writes ignored.
// - watchdog mode when mode-select and timer-enable are both 1.
// - watchdog overflow asserts overflow output; chip reset same cycle if enabled.
// - external reset beats overflow reset and leaves watchdog flag cleared.
// - overflow output lasts 132 states with reset-enable 1, else 130.
// - interval overflow sets timer overflow flag; interrupt follows that flag.
// - watchdog overflow with interrupt option raises non-maskable request.
// - protected registers take word writes only; byte writes ignored.
// - counter and timer_control share a write address, chosen by access key.
// - reset_control_status is written by word write at FF76 only.
// - clear write touches only the flag; config write loads bits 6 and 5.
// - byte reads: timer_control FF74, counter FF75, reset_control_status FF77.
// - counter write and increment in the same cycle: write wins.
// - while overflow output lasts (132 or 130 states) writes ignored and flag reads unacknowledged.
// - timer_control bit 3 picks non-maskable interrupt (0) or reset (1).
// - clock select picks system /2../131072 or subclock /2../256 tap.
`timescale 1ns/100ps
`include "wdt_regs.vh"

module wdt_timer #(
	parameter CNT_W = 8,
	parameter DIV_W = 17,
	parameter SUB_W = 8
) (
	input wire core_clk,
	input wire rst_n,
	input wire subClk,
	input wire [15:0] busAddr,
	input wire [15:0] busWdata,
	input wire busWrite,
	input wire busWord,
	input wire busRead,
	output reg [7:0] busRdata,
	output reg busRdAck,
	output reg overflowOut,
	output reg chipResetReq,
	output reg nmiReq,
	output reg intervalIrq
);

	// ****************************************
	// tap decoding
	// ****************************************
	function [DIV_W-1:0] sysMask;
		input [2:0] cks;
		begin
			case (cks)
				3'h0: sysMask = 17'h00001;
				3'h1: sysMask = 17'h0003f;
				3'h2: sysMask = 17'h0007f;
				3'h3: sysMask = 17'h001ff;
				3'h4: sysMask = 17'h007ff;
				3'h5: sysMask = 17'h01fff;
				3'h6: sysMask = 17'h07fff;
				default: sysMask = 17'h1ffff;
			endcase
		end
	endfunction

	function [SUB_W-1:0] subMask;
		input [2:0] cks;
		begin
			case (cks)
				3'h0: subMask = 8'h01;
				3'h1: subMask = 8'h03;
				3'h2: subMask = 8'h07;
				3'h3: subMask = 8'h0f;
				3'h4: subMask = 8'h1f;
				3'h5: subMask = 8'h3f;
				3'h6: subMask = 8'h7f;
				default: subMask = 8'hff;
			endcase
		end
	endfunction

	// ****************************************
	// state
	// ****************************************
	reg [7:0] ctrl_q;
	reg [7:0] ctrl_d;
	reg [CNT_W-1:0] cnt_q;
	reg [CNT_W-1:0] cnt_d;
	reg watchdog_overflow_flag_q;
	reg watchdog_overflow_flag_d;
	reg reset_enable_bit_q;
	reg reset_type_bit_q;
	reg wovfArm_q;
	reg ovfArm_q;
	reg [DIV_W-1:0] div_q;
	reg [SUB_W-1:0] subDiv_q;
	reg subPrev_q;
	reg [7:0] hold_q;

	// full-width copies so the narrow registers take explicit slices
	localparam [31:0] HOLD_RESET_ENABLE_BIT_W = `WDT_HOLD_RESET_ENABLE_BIT_CYC;
	localparam [31:0] HOLD_NORST_W = `WDT_HOLD_NORST_CYC;
	localparam [7:0] RST_INIT = `WDT_RESET_CONTROL_STATUS_RESET;

	wire [2:0] cks = ctrl_q[`WDT_CTRL_CKS_HI:`WDT_CTRL_CKS_LO];
	wire timer_enable_bit = ctrl_q[`WDT_CTRL_TME];
	wire wdMode = ctrl_q[`WDT_CTRL_MODE] & timer_enable_bit;
	wire holdActive = (hold_q != 8'h00);
	wire [7:0] rstRead = {watchdog_overflow_flag_q, reset_enable_bit_q, reset_type_bit_q, `WDT_RSV_ONES};

	// ****************************************
	// prescaler and counter tick
	// ****************************************
	wire subRise = subClk & ~subPrev_q;
	wire sysTick = ((div_q & sysMask(cks)) == sysMask(cks));
	wire subTick = subRise & ((subDiv_q & subMask(cks)) == subMask(cks));
	wire tick = timer_enable_bit & (ctrl_q[`WDT_CTRL_PSS] ? subTick : sysTick);

	always @(posedge core_clk) begin
		if (!rst_n || !timer_enable_bit) begin
			div_q <= {DIV_W{1'b0}};
			subDiv_q <= {SUB_W{1'b0}};
		end else begin
			div_q <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
			if (subRise) begin
				subDiv_q <= subDiv_q + {{(SUB_W-1){1'b0}}, 1'b1};
			end
		end
		if (!rst_n) begin
			subPrev_q <= 1'b0;
		end else begin
			subPrev_q <= subClk;
		end
	end

	// ****************************************
	// bus decode
	// ****************************************
	wire [7:0] key = busWdata[15:8];
	wire wrOk = busWrite & busWord & ~holdActive;
	wire wrShared = wrOk & (busAddr == `WDT_ADDR_CTRL);
	wire wrCtrl = wrShared & (key == `WDT_KEY_CTRL);
	wire wrCnt = wrShared & (key == `WDT_KEY_CNT);
	wire wrRst = wrOk & (busAddr == `WDT_ADDR_RSTW);
	wire wrClr = wrRst & (key == `WDT_KEY_WCLR) & ~busWdata[`WDT_RST_WATCHDOG_OVERFLOW_FLAG];
	wire wrCfg = wrRst & (key == `WDT_KEY_RCFG);
	wire rdRst = busRead & (busAddr == `WDT_ADDR_RSTR);
	wire rdAck = busRead & ~(rdRst & holdActive);
	wire rdCtrl = busRead & (busAddr == `WDT_ADDR_CTRL);

	// ****************************************
	// overflow events
	// ****************************************
	wire roll = tick & ~wrCnt & (cnt_q == {CNT_W{1'b1}});
	wire wdRoll = roll & wdMode;
	wire itRoll = roll & ~wdMode;
	wire actRst = ctrl_q[`WDT_CTRL_ACT];
	wire wdReset = wdRoll & actRst;

	always @* begin
		cnt_d = cnt_q;
		if (wrCnt) begin
			cnt_d = busWdata[CNT_W-1:0];
		end else if (tick) begin
			cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
		if (wdReset) begin
			cnt_d = `WDT_CNT_RESET;
		end
	end

	always @* begin
		ctrl_d = ctrl_q;
		if (wrCtrl) begin
			ctrl_d[6:0] = busWdata[6:0];
			if (!busWdata[`WDT_CTRL_OVF] && ovfArm_q) begin
				ctrl_d[`WDT_CTRL_OVF] = 1'b0;
			end
		end
		if (wdReset) begin
			ctrl_d = `WDT_CTRL_RESET;
		end else if (roll) begin
			ctrl_d[`WDT_CTRL_OVF] = 1'b1;
		end
	end

	always @* begin
		watchdog_overflow_flag_d = watchdog_overflow_flag_q;
		if (wrClr && wovfArm_q) begin
			watchdog_overflow_flag_d = 1'b0;
		end
		if (wdRoll) begin
			watchdog_overflow_flag_d = 1'b1;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_q <= `WDT_CTRL_RESET;
			cnt_q <= `WDT_CNT_RESET;
			watchdog_overflow_flag_q <= RST_INIT[`WDT_RST_WATCHDOG_OVERFLOW_FLAG];
			reset_enable_bit_q <= RST_INIT[`WDT_RST_RESET_ENABLE_BIT];
			reset_type_bit_q <= RST_INIT[`WDT_RST_RESET_TYPE_BIT];
			wovfArm_q <= 1'b0;
			ovfArm_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			cnt_q <= cnt_d;
			watchdog_overflow_flag_q <= watchdog_overflow_flag_d;
			if (wrCfg) begin
				reset_enable_bit_q <= busWdata[`WDT_RST_RESET_ENABLE_BIT];
				reset_type_bit_q <= busWdata[`WDT_RST_RESET_TYPE_BIT];
			end
			if (wrClr) begin
				wovfArm_q <= 1'b0;
			end else if (rdRst && rdAck && watchdog_overflow_flag_q) begin
				wovfArm_q <= 1'b1;
			end
			if (wrCtrl) begin
				ovfArm_q <= 1'b0;
			end else if (rdCtrl && ctrl_q[`WDT_CTRL_OVF]) begin
				ovfArm_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// overflow output, chip reset, interrupts
	// ****************************************
	always @(posedge core_clk) begin
		if (!rst_n) begin
			hold_q <= 8'h00;
			overflowOut <= 1'b0;
			chipResetReq <= 1'b0;
			nmiReq <= 1'b0;
			intervalIrq <= 1'b0;
		end else begin
			nmiReq <= wdRoll & ~actRst;
			intervalIrq <= ctrl_d[`WDT_CTRL_OVF] & ~wdMode;
			if (wdRoll) begin
				overflowOut <= 1'b1;
				chipResetReq <= actRst & reset_enable_bit_q;
				if (reset_enable_bit_q) begin
					hold_q <= HOLD_RESET_ENABLE_BIT_W[7:0];
				end else begin
					hold_q <= HOLD_NORST_W[7:0];
				end
			end else if (holdActive) begin
				hold_q <= hold_q - 8'h01;
				if (hold_q == 8'h01) begin
					overflowOut <= 1'b0;
					chipResetReq <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// byte read port
	// ****************************************
	always @(posedge core_clk) begin
		if (!rst_n) begin
			busRdata <= 8'h00;
			busRdAck <= 1'b0;
		end else begin
			busRdAck <= rdAck;
			if (!rdAck) begin
				busRdata <= 8'h00;
			end else begin
				case (busAddr)
					`WDT_ADDR_CTRL: busRdata <= ctrl_q;
					`WDT_ADDR_CNT: busRdata <= cnt_q;
					`WDT_ADDR_RSTR: busRdata <= rstRead;
					default: busRdata <= 8'h00;
				endcase
			end
		end
	end

endmodule

// ### verification/wdt_sys_model.sv
/* core reset and interrupt logic model: counts chip resets and nmi requests.
   assumes requests synchronous to core_clk */
`timescale 1ns/100ps
module wdt_sys_model (
	input wire core_clk,
	input wire chipResetReq,
	input wire nmiReq,
	output integer resetCount,
	output integer nmiCount
);
	reg rstSeen_q = 1'b0;
	initial begin
		resetCount = 0;
		nmiCount = 0;
	end
	always @(posedge core_clk) begin
		rstSeen_q <= chipResetReq;
		if (chipResetReq && !rstSeen_q)
			resetCount <= resetCount + 1;
		if (nmiReq)
			nmiCount <= nmiCount + 1;
	end
endmodule

// ### verification/wdt_timer_assertions.sv
/* port checker of wdt_timer.
   assumes one core_clk domain; attached by the bind below */
`timescale 1ns/100ps
module wdt_timer_chk (
	input wire core_clk,
	input wire rst_n,
	input wire subClk,
	input wire [15:0] busAddr,
	input wire [15:0] busWdata,
	input wire busWrite,
	input wire busWord,
	input wire busRead,
	input wire [7:0] busRdata,
	input wire busRdAck,
	input wire overflowOut,
	input wire chipResetReq,
	input wire nmiReq,
	input wire intervalIrq
);
	// ****
	// overflow output length
	// ****
	reg [7:0] ovCnt_q;
	always @(posedge core_clk) begin
		if (!rst_n || !overflowOut)
			ovCnt_q <= 8'h00;
		else
			ovCnt_q <= ovCnt_q + 8'h01;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_ovStart; $rose(overflowOut); endsequence
	sequence s_ovEnd; $fell(overflowOut); endsequence
	property p_rdAck; busRead && busAddr != 16'hff77 |=> busRdAck; endproperty
	a_rdAck: assert property (p_rdAck) else $error("read not acked");
	property p_noAck; !busRead |=> !busRdAck; endproperty
	a_noAck: assert property (p_noAck) else $error("ack without read");
	property p_rsvOnes;
		busRead && busAddr == 16'hff77 |=> !busRdAck || busRdata[4:0] == 5'h1f;
	endproperty
	a_rsvOnes: assert property (p_rsvOnes) else $error("low bits not ones");
	property p_holdNoAck; overflowOut && busRead && busAddr == 16'hff77 |=> !busRdAck; endproperty
	a_holdNoAck: assert property (p_holdNoAck) else $error("flag read acked in hold");
	property p_ovLen;
		s_ovEnd |-> ovCnt_q == 8'h84 || (ovCnt_q == 8'h82 && !$past(chipResetReq));
	endproperty
	a_ovLen: assert property (p_ovLen) else $error("overflow output length");
	property p_rstWithOv; chipResetReq |-> overflowOut; endproperty
	a_rstWithOv: assert property (p_rstWithOv) else $error("reset without overflow");
	property p_rstStart; $rose(chipResetReq) |-> s_ovStart; endproperty
	a_rstStart: assert property (p_rstStart) else $error("reset not with overflow");
	property p_nmi; nmiReq |-> s_ovStart ##1 !nmiReq; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi pulse wrong");
endmodule

bind wdt_timer wdt_timer_chk chk (.core_clk(core_clk), .rst_n(rst_n), .subClk(subClk),
	.busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite), .busWord(busWord),
	.busRead(busRead), .busRdata(busRdata), .busRdAck(busRdAck), .overflowOut(overflowOut),
	.chipResetReq(chipResetReq), .nmiReq(nmiReq), .intervalIrq(intervalIrq));

// ### verification/wdt_timer_test.sv
/* self-checking bench of wdt_timer: access, watchdog and interval runs.
   assumes the checker is bound and the reset model sits beside the timer */
`timescale 1ns/100ps
module wdt_timer_test;
	reg core_clk = 1'b0;
	reg rst_n = 1'b0;
	reg [15:0] busAddr = 16'h0000;
	reg [15:0] busWdata = 16'h0000;
	reg busWrite = 1'b0;
	reg busWord = 1'b0;
	reg busRead = 1'b0;
	wire [7:0] busRdata;
	wire busRdAck, overflowOut, chipResetReq, nmiReq, intervalIrq;
	integer num_errors = 0, n_tests = 0, cyc = 0, ovLen = 0, rstLen = 0, i;
	integer resetCount, nmiCount;
	always #2 core_clk = ~core_clk;
	wdt_timer uut (.core_clk(core_clk), .rst_n(rst_n), .subClk(1'b0), .busAddr(busAddr),
		.busWdata(busWdata), .busWrite(busWrite), .busWord(busWord), .busRead(busRead),
		.busRdata(busRdata), .busRdAck(busRdAck), .overflowOut(overflowOut),
		.chipResetReq(chipResetReq), .nmiReq(nmiReq), .intervalIrq(intervalIrq));
	wdt_sys_model sys (.core_clk(core_clk), .chipResetReq(chipResetReq), .nmiReq(nmiReq),
		.resetCount(resetCount), .nmiCount(nmiCount));
	// ****
	// tasks
	// ****
	task results;
		begin
			$display("checks %0d mismatches %0d", n_tests, num_errors);
			if (num_errors == 0 && n_tests > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		ovLen <= ovLen + (overflowOut === 1'b1);
		rstLen <= rstLen + (chipResetReq === 1'b1);
		if (cyc == 3000) begin
			num_errors = num_errors + 1;
			results;
		end
	end
	task cmp(input [8*8-1:0] name, input [7:0] exp, input [7:0] got);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	task wr(input [15:0] a, input [15:0] d, input w);
		begin
			@(negedge core_clk);
			busAddr = a;
			busWdata = d;
			busWord = w;
			busWrite = 1'b1;
			@(negedge core_clk);
			busWrite = 1'b0;
		end
	endtask
	task rd(input [15:0] a, input [7:0] exp, input ack);
		begin
			@(negedge core_clk);
			busAddr = a;
			busRead = 1'b1;
			@(negedge core_clk);
			busRead = 1'b0;
			cmp("rdAck", {7'h00, ack}, {7'h00, busRdAck});
			if (ack)
				cmp("rdData", exp, busRdata);
		end
	endtask
	task ovRun(input [7:0] data, input [7:0] expLen, input [7:0] expRst);
		integer k;
		begin
			wr(16'hff74, 16'h5afd, 1'b1);
			wr(16'hff74, {8'ha5, data}, 1'b1);
			ovLen = 0;
			rstLen = 0;
			for (k = 0; k < 40 && overflowOut !== 1'b1; k = k + 1)
				@(negedge core_clk);
			rd(16'hff77, 8'h00, 1'b0);
			wr(16'hff74, 16'h5a11, 1'b1);
			for (k = 0; k < 200 && overflowOut === 1'b1; k = k + 1)
				@(negedge core_clk);
			cmp("ovLen", expLen, ovLen[7:0]);
			cmp("rstLen", expRst, rstLen[7:0]);
		end
	endtask
	// ****
	// tests
	// ****
	initial begin
		repeat (8) @(negedge core_clk);
		rst_n = 1'b1;
		rd(16'hff77, 8'h1f, 1'b1);
		rd(16'hff74, 8'h00, 1'b1);
		rd(16'hff70, 8'h00, 1'b1);
		wr(16'hff74, 16'h5a33, 1'b0);
		wr(16'hff74, 16'h1244, 1'b1);
		rd(16'hff75, 8'h00, 1'b1);
		wr(16'hff74, 16'h5a33, 1'b1);
		rd(16'hff75, 8'h33, 1'b1);
		wr(16'hff74, 16'ha507, 1'b1);
		rd(16'hff74, 8'h07, 1'b1);
		wr(16'hff76, 16'h5a40, 1'b0);
		rd(16'hff77, 8'h1f, 1'b1);
		wr(16'hff76, 16'h5a4a, 1'b1);
		rd(16'hff77, 8'h5f, 1'b1);
		$display("test access done");
		ovRun(8'h68, 8'h84, 8'h84);
		rd(16'hff75, 8'h00, 1'b1);
		rd(16'hff74, 8'h00, 1'b1);
		rd(16'hff77, 8'hdf, 1'b1);
		wr(16'hff76, 16'ha580, 1'b1);
		rd(16'hff77, 8'hdf, 1'b1);
		wr(16'hff76, 16'ha500, 1'b1);
		rd(16'hff77, 8'h5f, 1'b1);
		cmp("resets", 8'h01, resetCount[7:0]);
		wr(16'hff76, 16'h5a00, 1'b1);
		ovRun(8'h68, 8'h82, 8'h00);
		rd(16'hff74, 8'h00, 1'b1);
		rd(16'hff77, 8'h9f, 1'b1);
		wr(16'hff76, 16'ha500, 1'b1);
		$display("test watchdog reset done");
		ovRun(8'h60, 8'h82, 8'h00);
		cmp("nmis", 8'h01, nmiCount[7:0]);
		rd(16'hff74, 8'he0, 1'b1);
		wr(16'hff74, 16'ha500, 1'b1);
		rd(16'hff74, 8'h00, 1'b1);
		rd(16'hff77, 8'h9f, 1'b1);
		wr(16'hff76, 16'ha500, 1'b1);
		$display("test watchdog nmi done");
		wr(16'hff74, 16'h5afd, 1'b1);
		wr(16'hff74, 16'ha520, 1'b1);
		for (i = 0; i < 40 && intervalIrq !== 1'b1; i = i + 1)
			@(negedge core_clk);
		cmp("irq", 8'h01, {7'h00, intervalIrq});
		cmp("ovOut", 8'h00, {7'h00, overflowOut});
		rd(16'hff74, 8'ha0, 1'b1);
		rd(16'hff74, 8'ha0, 1'b1);
		rd(16'hff77, 8'h1f, 1'b1);
		wr(16'hff74, 16'ha500, 1'b1);
		@(negedge core_clk);
		cmp("irq", 8'h00, {7'h00, intervalIrq});
		$display("test interval done");
		results;
	end
endmodule
